/* core/ccsc_cfg.svh */
`ifndef CCSC_CFG_SVH
`define CCSC_CFG_SVH

`define CCSC_AW         4
`define CCSC_WORDS      16
`define CCSC_LAST_ADDR  4'hF
`define CCSC_NPORT      5
`define CCSC_NSPINS     10
`define CCSC_NTPINS     5
`define CCSC_PORT_NVM   3'h0
`define CCSC_PORT_JTAG  3'h1
`define CCSC_PORT_MSPI  3'h2
`define CCSC_PORT_SLAVE_SERIAL_CONFIG  3'h3
`define CCSC_PORT_I2C   3'h4
`define CCSC_MASK_NONE  10'h000
`define CCSC_MASK_MSPI  10'h03F
`define CCSC_MASK_SLAVE_SERIAL_CONFIG  10'h0F3
`define CCSC_MASK_I2C   10'h300
`define CCSC_TAP_EN_BIT 4
`define CCSC_CRC_POLY   8'h07
`define CCSC_CRC_INIT   8'hFF
`define CCSC_ZERO8      8'h00
`define CCSC_ZERO4      4'h0
`define CCSC_SED_DIV    4'h7
`define CCSC_ID_CODE    32'h0C5C_0001
`define CCSC_KEY_RST    32'h0000_0000

`endif

/* core/ccsc_pkg.sv */
package ccsc_pkg;

   typedef struct packed
   {
      logic       req;
      logic       valid;
      logic [7:0] data;
   } ccsc_port_s;

   typedef enum logic [3:0]
   {
      CCSC_OP_READ_ID,
      CCSC_OP_READBACK,
      CCSC_OP_PROGRAM,
      CCSC_OP_VERIFY,
      CCSC_OP_ERASE,
      CCSC_OP_REFRESH,
      CCSC_OP_SET_LOCK,
      CCSC_OP_SET_OTP
   } ccsc_op_e;

   typedef struct packed
   {
      ccsc_op_e    op;
      logic [3:0]  addr;
      logic [7:0]  data;
      logic [31:0] key;
   } ccsc_cmd_s;

   typedef enum logic [2:0]
   {
      CCSC_S_IDLE,
      CCSC_S_LOAD,
      CCSC_S_SED,
      CCSC_S_USER,
      CCSC_S_FIX,
      CCSC_S_WIPE,
      CCSC_S_RELOAD
   } ccsc_state_e;

endpackage

/* core/ccsc_top.sv */
`timescale 1ns/1ps
`include "ccsc_cfg.svh"

module ccsc_top
   import ccsc_pkg::*;
(
   input  wire logic                     ref_clk,
   input  wire logic                     rst_b,
   input  wire logic                     clk_en,
   input  wire ccsc_port_s [4:0]         port_in,
   input  wire logic                     dual_boot_en,
   input  wire logic                     sed_after_cfg,
   input  wire logic                     sed_enable,
   input  wire logic                     sed_request,
   input  wire logic                     background_refresh_enable,
   input  wire logic                     program_request_n,
   input  wire logic                     key_enable,
   input  wire logic                     tap_as_gpio,
   input  wire logic                     cmd_valid,
   input  wire ccsc_cmd_s                cmd,
   output logic                          cmd_done,
   output logic                          cmd_refused,
   output logic [31:0]                   rsp_data,
   output logic                          user_mode,
   output logic                          user_reset,
   output logic                          busy,
   output logic [2:0]                    active_port,
   output logic                          load_fail,
   output logic                          soft_error_flag,
   output logic [3:0]                    soft_error_addr,
   output logic                          secure_locked,
   output logic                          otp_set,
   output logic [9:0]                    serial_pins_cfg,
   output logic [4:0]                    tap_pins_cfg
);

   parameter logic [31:0] STORED_KEY = `CCSC_KEY_RST;

   // -----------------------------------------------------------------
   // Storage and helpers
   // -----------------------------------------------------------------
   logic [7:0] sram   [`CCSC_WORDS];
   logic [7:0] chk    [`CCSC_WORDS];
   logic [7:0] shadow [`CCSC_WORDS];
   logic [7:0] nvm    [`CCSC_WORDS];

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++)
      begin
         r = r[7] ? ((r << 1) ^ `CCSC_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction

   function automatic logic [9:0] pin_mask(input logic [2:0] p);
      case (p)
         `CCSC_PORT_MSPI: pin_mask = `CCSC_MASK_MSPI;
         `CCSC_PORT_SLAVE_SERIAL_CONFIG: pin_mask = `CCSC_MASK_SLAVE_SERIAL_CONFIG;
         `CCSC_PORT_I2C:  pin_mask = `CCSC_MASK_I2C;
         default:         pin_mask = `CCSC_MASK_NONE;
      endcase
   endfunction

   ccsc_state_e state_r;
   logic [2:0]  sel_r;
   logic [3:0]  cnt_r;
   logic [7:0]  crc_r;
   logic [3:0]  div_r;
   logic        sed_err_r;
   logic        sed_req_d_r;
   logic        prog_d_r;
   logic        lock_r;
   logic        otp_r;
   logic        fail_r;
   logic        serr_r;
   logic [3:0]  eaddr_r;

   // -----------------------------------------------------------------
   // Source selection and word intake
   // -----------------------------------------------------------------
   logic [2:0] pick;
   logic       any_req;
   always_comb
   begin
      pick    = `CCSC_PORT_NVM;
      any_req = 1'b0;
      for (int i = `CCSC_NPORT - 1; i >= 0; i--)
      begin
         if (port_in[i].req)
         begin
            pick    = 3'(i);
            any_req = 1'b1;
         end
      end
   end

   logic       w_valid;
   logic [7:0] w_data;
   always_comb
   begin
      // Internal memory streams a word per cycle; ports are paced.
      if (sel_r == `CCSC_PORT_NVM)
      begin
         w_valid = 1'b1;
         w_data  = nvm[cnt_r];
      end
      else
      begin
         w_valid = port_in[sel_r].valid;
         w_data  = port_in[sel_r].data;
      end
   end

   logic load_wr;
   logic crc_word;
   logic crc_bad;
   assign load_wr  = (state_r == CCSC_S_LOAD) && w_valid && !crc_word;
   // The internal image is trusted and carries no trailing check word.
   assign crc_word = sed_err_r && (sel_r != `CCSC_PORT_NVM);
   assign crc_bad  = (w_data != crc_r);

   // -----------------------------------------------------------------
   // Soft-error check clock divider
   // -----------------------------------------------------------------
   // Derived as an enable from the undivided clock, so that no second
   // clock domain is needed; switching it off stops every tick.
   logic sed_tick;
   assign sed_tick = sed_enable && (div_r == `CCSC_SED_DIV);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         div_r <= `CCSC_ZERO4;
      end
      else if (clk_en)
      begin
         if (!sed_enable || sed_tick)
         begin
            div_r <= `CCSC_ZERO4;
         end
         else
         begin
            div_r <= div_r + 4'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Triggers
   // -----------------------------------------------------------------
   logic cmd_ok;
   logic key_ok;
   logic idle_cmd;
   logic do_refresh;
   logic prog_fall;
   assign key_ok    = !key_enable || (cmd.key == STORED_KEY);
   assign idle_cmd  = (state_r == CCSC_S_IDLE) || (state_r == CCSC_S_USER);
   assign prog_fall = prog_d_r && !program_request_n;
   assign do_refresh = (state_r == CCSC_S_USER) && (prog_fall ||
                       (cmd_valid && cmd_ok &&
                        cmd.op == CCSC_OP_REFRESH));

   always_comb
   begin
      case (cmd.op)
         CCSC_OP_READ_ID:  cmd_ok = 1'b1;
         CCSC_OP_READBACK: cmd_ok = !lock_r;
         CCSC_OP_PROGRAM,
         CCSC_OP_ERASE:    cmd_ok = key_ok && !otp_r;
         CCSC_OP_VERIFY:   cmd_ok = key_ok;
         CCSC_OP_REFRESH:  cmd_ok = key_ok;
         CCSC_OP_SET_LOCK,
         CCSC_OP_SET_OTP:  cmd_ok = key_ok;
         default:          cmd_ok = 1'b0;
      endcase
   end

   logic erase_go;
   assign erase_go = cmd_valid && idle_cmd && cmd_ok &&
                     (cmd.op == CCSC_OP_ERASE);

   // -----------------------------------------------------------------
   // Configuration sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r   <= CCSC_S_IDLE;
         sel_r     <= `CCSC_PORT_NVM;
         cnt_r     <= `CCSC_ZERO4;
         crc_r     <= `CCSC_CRC_INIT;
         sed_err_r <= 1'b0;
      end
      else if (clk_en)
      begin
         case (state_r)
            CCSC_S_IDLE:
            begin
               if (any_req && !erase_go)
               begin
                  state_r   <= CCSC_S_LOAD;
                  sel_r     <= pick;
                  cnt_r     <= `CCSC_ZERO4;
                  crc_r     <= `CCSC_CRC_INIT;
                  sed_err_r <= 1'b0;
               end
            end
            CCSC_S_LOAD:
            begin
               // Other ports are not looked at until this load ends.
               if (w_valid && crc_word)
               begin
                  if (crc_bad && dual_boot_en &&
                      sel_r == `CCSC_PORT_MSPI)
                  begin
                     sel_r     <= `CCSC_PORT_NVM;
                     cnt_r     <= `CCSC_ZERO4;
                     crc_r     <= `CCSC_CRC_INIT;
                     sed_err_r <= 1'b0;
                  end
                  else if (crc_bad)
                  begin
                     state_r <= CCSC_S_IDLE;
                  end
                  else
                  begin
                     state_r   <= sed_after_cfg && sed_enable ?
                                  CCSC_S_SED : CCSC_S_USER;
                     cnt_r     <= `CCSC_ZERO4;
                     sed_err_r <= 1'b0;
                  end
               end
               else if (load_wr)
               begin
                  crc_r <= crc8(crc_r, w_data);
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `CCSC_LAST_ADDR)
                  begin
                     if (sel_r == `CCSC_PORT_NVM)
                     begin
                        state_r <= sed_after_cfg && sed_enable ?
                                   CCSC_S_SED : CCSC_S_USER;
                     end
                     // Flag reused: next word is the check word.
                     sed_err_r <= sel_r != `CCSC_PORT_NVM;
                  end
               end
            end
            CCSC_S_SED:
            begin
               if (!sed_enable)
               begin
                  state_r <= CCSC_S_USER;
               end
               else if (sed_tick)
               begin
                  cnt_r <= cnt_r + 4'h1;
                  if (cnt_r == `CCSC_LAST_ADDR)
                  begin
                     state_r <= CCSC_S_USER;
                  end
               end
            end
            CCSC_S_USER:
            begin
               if (port_in[`CCSC_PORT_JTAG].req)
               begin
                  state_r   <= CCSC_S_LOAD;
                  sel_r     <= `CCSC_PORT_JTAG;
                  cnt_r     <= `CCSC_ZERO4;
                  crc_r     <= `CCSC_CRC_INIT;
                  sed_err_r <= 1'b0;
               end
               else if (do_refresh)
               begin
                  state_r <= background_refresh_enable ?
                             CCSC_S_FIX : CCSC_S_WIPE;
               end
               else if (sed_request && !sed_req_d_r && sed_enable)
               begin
                  state_r <= CCSC_S_SED;
                  cnt_r   <= `CCSC_ZERO4;
               end
            end
            CCSC_S_FIX:
            begin
               state_r <= CCSC_S_USER;
            end
            CCSC_S_WIPE:
            begin
               state_r <= CCSC_S_RELOAD;
               cnt_r   <= `CCSC_ZERO4;
            end
            CCSC_S_RELOAD:
            begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == `CCSC_LAST_ADDR)
               begin
                  state_r <= CCSC_S_USER;
               end
            end
            default:
            begin
               state_r <= CCSC_S_IDLE;
            end
         endcase
         if (erase_go)
         begin
            state_r <= CCSC_S_IDLE;
         end
      end
   end

   // -----------------------------------------------------------------
   // Memory writes
   // -----------------------------------------------------------------
   // Arrays carry no reset; sram, shadow and chk are defined by the first load, nvm by program or erase.
   always_ff @(posedge ref_clk)
   begin
      if (clk_en)
      begin
         if (erase_go)
         begin
            for (int i = 0; i < `CCSC_WORDS; i++)
            begin
               sram[i] <= `CCSC_ZERO8;
               nvm[i]  <= `CCSC_ZERO8;
            end
         end
         else if (state_r == CCSC_S_WIPE)
         begin
            for (int i = 0; i < `CCSC_WORDS; i++)
            begin
               sram[i] <= `CCSC_ZERO8;
            end
         end
         else if (load_wr)
         begin
            sram[cnt_r]   <= w_data;
            shadow[cnt_r] <= w_data;
            chk[cnt_r]    <= crc8(`CCSC_CRC_INIT, w_data);
         end
         else if (state_r == CCSC_S_FIX)
         begin
            sram[eaddr_r] <= shadow[eaddr_r];
         end
         else if (state_r == CCSC_S_RELOAD)
         begin
            sram[cnt_r] <= shadow[cnt_r];
         end
         if (cmd_valid && idle_cmd && cmd_ok &&
             cmd.op == CCSC_OP_PROGRAM)
         begin
            nvm[cmd.addr] <= cmd.data;
         end
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   logic sed_hit;
   assign sed_hit = (state_r == CCSC_S_SED) && sed_tick &&
                    (crc8(`CCSC_CRC_INIT, sram[cnt_r]) != chk[cnt_r]);

   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         fail_r      <= 1'b0;
         serr_r      <= 1'b0;
         eaddr_r     <= `CCSC_ZERO4;
         sed_req_d_r <= 1'b0;
         prog_d_r    <= 1'b1;
      end
      else if (clk_en)
      begin
         sed_req_d_r <= sed_request;
         prog_d_r    <= program_request_n;
         if (state_r == CCSC_S_LOAD && w_valid && crc_word && crc_bad)
         begin
            fail_r <= 1'b1;
         end
         else if (state_r == CCSC_S_IDLE && any_req)
         begin
            fail_r <= 1'b0;
         end
         // A new error wins over the clear by a repair in the same cycle.
         if (sed_hit && !serr_r)
         begin
            serr_r  <= 1'b1;
            eaddr_r <= cnt_r;
         end
         else if (state_r == CCSC_S_FIX || state_r == CCSC_S_RELOAD)
         begin
            serr_r <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // Security and command answers
   // -----------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lock_r      <= 1'b0;
         otp_r       <= 1'b0;
         cmd_done    <= 1'b0;
         cmd_refused <= 1'b0;
         rsp_data    <= `CCSC_KEY_RST;
      end
      else if (clk_en)
      begin
         cmd_done    <= cmd_valid && idle_cmd && cmd_ok;
         cmd_refused <= cmd_valid && !(idle_cmd && cmd_ok);
         if (cmd_valid && idle_cmd && cmd_ok)
         begin
            case (cmd.op)
               CCSC_OP_READ_ID:  rsp_data <= `CCSC_ID_CODE;
               CCSC_OP_READBACK: rsp_data <= {16'h0000,
                                   nvm[cmd.addr], sram[cmd.addr]};
               CCSC_OP_VERIFY:   rsp_data <= {31'h0,
                                   nvm[cmd.addr] == cmd.data};
               CCSC_OP_SET_LOCK: lock_r <= 1'b1;
               CCSC_OP_SET_OTP:  otp_r <= 1'b1;
               CCSC_OP_ERASE:    lock_r <= 1'b0;
               default:          rsp_data <= rsp_data;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Outputs and pin release
   // -----------------------------------------------------------------
   logic loading;
   assign loading         = (state_r == CCSC_S_LOAD);
   assign user_mode       = (state_r == CCSC_S_USER) ||
                            (state_r == CCSC_S_SED && sed_enable) ||
                            (state_r == CCSC_S_FIX);
   assign user_reset      = (state_r == CCSC_S_WIPE) ||
                            (state_r == CCSC_S_RELOAD);
   assign busy            = !idle_cmd;
   assign active_port     = sel_r;
   assign load_fail       = fail_r;
   assign soft_error_flag = serr_r;
   assign soft_error_addr = eaddr_r;
   assign secure_locked   = lock_r;
   assign otp_set         = otp_r;
   assign serial_pins_cfg = loading ? pin_mask(sel_r) :
                            `CCSC_MASK_NONE;

   generate
      for (genvar g = 0; g < `CCSC_NTPINS; g++)
      begin : g_tap
         if (g == `CCSC_TAP_EN_BIT)
         begin : g_en
            assign tap_pins_cfg[g] = 1'b1;
         end
         else
         begin : g_io
            assign tap_pins_cfg[g] = !tap_as_gpio;
         end
      end
   endgenerate

endmodule // ccsc_top

/* testbench/ccsc_flash_model.sv */
`timescale 1ns/1ps
module ccsc_flash_model
   import ccsc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       go,
   input  wire logic       bad,
   input  wire logic [7:0] base,
   output ccsc_port_s      pout
);
   logic [4:0] cnt_r;
   logic [7:0] crc;

   function automatic logic [7:0] word(input logic [7:0] b, input int k);
      return b + 8'h1D * k[7:0];
   endfunction

   always_comb
   begin
      crc = 8'hFF;
      for (int k = 0; k < 16; k++)
      begin
         crc = crc ^ word(base, k);
         for (int j = 0; j < 8; j++)
            crc = crc[7] ? {crc[6:0], 1'b0} ^ 8'h07 : {crc[6:0], 1'b0};
      end
   end

   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         cnt_r <= 5'h00;
      else if (cnt_r == 5'h00)
         cnt_r <= go ? 5'h01 : 5'h00;
      else
         cnt_r <= (cnt_r == 5'h12) ? 5'h00 : cnt_r + 5'h01;

   // Outside a frame valid is low and the data lines carry a counter pattern, 8'h1F while idle, so a stale word never passes.
   always_comb
   begin
      pout.req   = (cnt_r == 5'h01);
      pout.valid = (cnt_r >= 5'h02);
      pout.data  = {cnt_r[2:0], ~cnt_r};
      if (cnt_r >= 5'h02 && cnt_r <= 5'h11)
         pout.data = word(base, cnt_r - 5'h02);
      else if (cnt_r == 5'h12)
         pout.data = crc ^ {7'h00, bad};
   end
endmodule // ccsc_flash_model

/* testbench/ccsc_top_chk.sv */
`timescale 1ns/1ps
`include "ccsc_cfg.svh"
module ccsc_top_chk
   import ccsc_pkg::*;
#(
   parameter logic [31:0] STORED_KEY = 32'h0000_0000
)
(
   input wire logic       ref_clk,
   input wire logic       rst_b,
   input wire logic       key_enable,
   input wire logic       tap_as_gpio,
   input wire logic       background_refresh_enable,
   input wire logic       program_request_n,
   input wire logic       cmd_valid,
   input wire ccsc_cmd_s  cmd,
   input wire logic       cmd_done,
   input wire logic       cmd_refused,
   input wire logic       user_mode,
   input wire logic       user_reset,
   input wire logic       busy,
   input wire logic [2:0] active_port,
   input wire logic       load_fail,
   input wire logic       secure_locked,
   input wire logic       otp_set,
   input wire logic [9:0] serial_pins_cfg,
   input wire logic [4:0] tap_pins_cfg
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic edit_op;
   logic erase_q1_r;
   logic erase_q2_r;
   assign edit_op = cmd.op inside {CCSC_OP_PROGRAM, CCSC_OP_VERIFY,
                                   CCSC_OP_ERASE};
   always_ff @(posedge ref_clk)
   begin
      erase_q1_r <= cmd_valid && cmd.op == CCSC_OP_ERASE;
      erase_q2_r <= erase_q1_r;
   end

   chk_port_hold: assert property (busy && !user_mode && $past(busy)
      && !$past(user_mode) |-> $stable(active_port)
      || active_port == `CCSC_PORT_NVM) else $error("port changed in load");
   chk_tap_pins: assert property (tap_pins_cfg
      == {1'b1, {4{!tap_as_gpio}}}) else $error("test pins wrong");
   chk_pins_free: assert property (!busy
      |-> serial_pins_cfg == `CCSC_MASK_NONE) else $error("pins kept");
   chk_lock_clear: assert property ($fell(secure_locked)
      |-> erase_q1_r || erase_q2_r) else $error("lock cleared");
   chk_otp_keep: assert property (otp_set |=> otp_set)
      else $error("one-time mode lost");
   chk_otp_erase: assert property (otp_set && cmd_valid
      && cmd.op == CCSC_OP_ERASE |-> ##[1:2] cmd_refused)
      else $error("erase allowed");
   chk_read_lock: assert property (secure_locked && cmd_valid
      && cmd.op == CCSC_OP_READBACK |-> ##[1:2] cmd_refused)
      else $error("readback allowed");
   chk_key_gate: assert property (key_enable && cmd_valid && edit_op
      && cmd.key != STORED_KEY |-> ##[1:2] cmd_refused)
      else $error("bad key accepted");
   chk_id_free: assert property (cmd_valid && !busy
      && cmd.op == CCSC_OP_READ_ID |-> ##[1:2] cmd_done)
      else $error("id read refused");
   chk_reset_len: assert property ($rose(user_reset) |->
      user_reset [*8] ##1 user_reset [*8] ##1 user_reset ##1 !user_reset)
      else $error("soft reset length");
   chk_fix_quiet: assert property (user_mode && !busy
      && background_refresh_enable && $fell(program_request_n)
      |-> ##1 !user_reset [*3]) else $error("refresh reset logic");
   chk_one_answer: assert property (!(cmd_done && cmd_refused))
      else $error("done and refused");

   cover property ($rose(load_fail));
   cover property ($rose(user_reset));
   cover property ($rose(secure_locked));
endmodule // ccsc_top_chk

/* testbench/test_config_security_seu_control.sv */
`timescale 1ns/1ps
`include "ccsc_cfg.svh"
module test_config_security_seu_control
   import ccsc_pkg::*;
;
   localparam logic [31:0] KEY = 32'hA5C3_0F1E;
   logic ref_clk, rst_b, clk_en, dual_boot_en, sed_after_cfg, sed_enable;
   logic sed_request, background_refresh_enable, program_request_n;
   logic key_enable, tap_as_gpio, cmd_valid, go, bad, noise;
   logic cmd_done, cmd_refused, user_mode, user_reset, busy, load_fail;
   logic soft_error_flag, secure_locked, otp_set;
   logic [31:0]      rsp_data;
   logic [2:0]       active_port, mport;
   logic [3:0]       soft_error_addr, a;
   logic [9:0]       serial_pins_cfg;
   logic [4:0]       tap_pins_cfg;
   logic [7:0]       base, d, r8;
   logic [15:0]      lfsr_r;
   ccsc_cmd_s        cmd;
   ccsc_port_s [4:0] port_in;
   ccsc_port_s       fm;
   int               n_fail, comparisons, i, n;

   ccsc_top #(.STORED_KEY(KEY)) u_dut (.*);
   ccsc_flash_model u_flash (.clk(ref_clk), .rst_b(rst_b), .go(go),
      .bad(bad), .base(base), .pout(fm));

   always_comb
   begin
      port_in = '0;
      port_in[mport] = fm;
      port_in[4].req = port_in[4].req | noise;
   end

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   function logic [7:0] rnd();
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12]
                ^ lfsr_r[10]};
      return lfsr_r[7:0];
   endfunction
   function automatic logic [7:0] exp_w(input logic [7:0] b, k);
      return b + 8'h1D * k;
   endfunction

   task tick();
      @(posedge ref_clk);
      #1;
   endtask
   task chk1(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task chkw(input logic [31:0] got, exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task do_cmd(input ccsc_op_e op, input logic [3:0] ad,
               input logic [7:0] dt, input logic [31:0] k, input logic ok);
      int j;
      cmd = '{op, ad, dt, k};
      cmd_valid = 1'b1;
      tick();
      cmd_valid = 1'b0;
      for (j = 0; j < 4 && !(cmd_done | cmd_refused); j++)
         tick();
      chk1(cmd_done, ok, "command answer");
      chk1(cmd_refused, !ok, "command refusal");
      tick();
   endtask
   task load(input logic [2:0] p, input logic b);
      mport = p;
      bad = b;
      go = 1'b1;
      tick();
      go = 1'b0;
   endtask
   task end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Watchdog: the whole sequence needs about five hundred cycles.
   // ----------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      $display("unexpected at %0t: watchdog expired", $time);
      end_sim();
   end

   initial
   begin
      {rst_b, dual_boot_en, sed_after_cfg, sed_enable, sed_request} = '0;
      {background_refresh_enable, tap_as_gpio, cmd_valid, go, bad} = '0;
      {noise, n_fail, comparisons, cmd} = '0;
      {clk_en, key_enable, program_request_n} = 3'h7;
      mport = 3'h3;
      base = 8'h00;
      lfsr_r = 16'hF93A;
      repeat (10) @(posedge ref_clk);
      #1 rst_b = 1'b1;
      chk1(secure_locked | otp_set | user_mode, 1'b0, "reset state");
      do_cmd(CCSC_OP_READ_ID, 4'h0, 8'h00, ~KEY, 1'b1);
      chkw(rsp_data, `CCSC_ID_CODE, "id");
      r8 = rnd();
      a = r8[3:0];
      d = rnd();
      do_cmd(CCSC_OP_PROGRAM, a, d, KEY ^ 32'h1, 1'b0);
      do_cmd(CCSC_OP_PROGRAM, a, d, KEY, 1'b1);
      do_cmd(CCSC_OP_VERIFY, a, d, KEY, 1'b1);
      chk1(rsp_data[0], 1'b1, "verify");
      base = rnd();
      load(3'h3, 1'b0);
      noise = 1'b1;
      for (i = 0; i < 16; i++)
      begin
         tick();
         chk1(active_port === `CCSC_PORT_SLAVE_SERIAL_CONFIG, 1'b1, "port");
         chk1(serial_pins_cfg === `CCSC_MASK_SLAVE_SERIAL_CONFIG, 1'b1, "pins");
      end
      noise = 1'b0;
      for (i = 0; i < 8 && user_mode !== 1'b1; i++)
         tick();
      chk1(user_mode, 1'b1, "user mode");
      for (i = 0; i < 16; i++)
      begin
         do_cmd(CCSC_OP_READBACK, i[3:0], 8'h00, 32'h0, 1'b1);
         chkw({24'h0, rsp_data[7:0]}, {24'h0, exp_w(base, i[7:0])}, "rb");
      end
      do_cmd(CCSC_OP_READBACK, a, 8'h00, 32'h0, 1'b1);
      chkw(rsp_data, {16'h0, d, exp_w(base, {4'h0, a})}, "rb nvm");
      tap_as_gpio = 1'b1;
      tick();
      chk1(tap_pins_cfg === 5'h10, 1'b1, "tap pins");
      sed_request = 1'b1;
      for (i = 0; i < 4; i++)
      begin
         tick();
         chk1(busy, 1'b0, "check while off");
      end
      sed_request = 1'b0;
      tick();
      sed_enable = 1'b1;
      sed_request = 1'b1;
      tick();
      tick();
      chk1(busy & user_mode, 1'b1, "check running");
      for (i = 0; i < 200 && busy; i++)
         tick();
      chk1(busy | soft_error_flag | (|soft_error_addr), 1'b0,
           "check result");
      sed_request = 1'b0;
      background_refresh_enable = 1'b1;
      program_request_n = 1'b0;
      for (i = 0; i < 4; i++)
      begin
         tick();
         chk1(user_reset, 1'b0, "fix reset");
      end
      program_request_n = 1'b1;
      tick();
      background_refresh_enable = 1'b0;
      program_request_n = 1'b0;
      n = 0;
      for (i = 0; i < 40; i++)
      begin
         tick();
         n += user_reset;
      end
      chkw(n, 32'h11, "soft reset cycles");
      program_request_n = 1'b1;
      sed_after_cfg = 1'b1;
      base = rnd();
      load(3'h1, 1'b0);
      tick();
      for (i = 0; i < 300 && (busy || !user_mode); i++)
         tick();
      chk1(active_port === `CCSC_PORT_JTAG, 1'b1, "test port");
      chk1(user_mode & !soft_error_flag, 1'b1, "after check");
      do_cmd(CCSC_OP_READBACK, 4'h5, 8'h00, 32'h0, 1'b1);
      chkw({24'h0, rsp_data[7:0]}, {24'h0, exp_w(base, 8'h05)}, "rb2");
      do_cmd(CCSC_OP_SET_LOCK, 4'h0, 8'h00, KEY, 1'b1);
      chk1(secure_locked, 1'b1, "locked");
      do_cmd(CCSC_OP_READBACK, a, 8'h00, 32'h0, 1'b0);
      do_cmd(CCSC_OP_ERASE, 4'h0, 8'h00, KEY, 1'b1);
      chk1(secure_locked | user_mode, 1'b0, "erased");
      dual_boot_en = 1'b1;
      sed_after_cfg = 1'b0;
      load(3'h2, 1'b1);
      for (i = 0; i < 60 && user_mode !== 1'b1; i++)
         tick();
      chk1(user_mode & load_fail, 1'b1, "golden boot");
      chk1(active_port === `CCSC_PORT_NVM, 1'b1, "golden port");
      do_cmd(CCSC_OP_READBACK, a, 8'h00, 32'h0, 1'b1);
      chkw(rsp_data, 32'h0, "golden image");
      do_cmd(CCSC_OP_SET_OTP, 4'h0, 8'h00, KEY, 1'b1);
      do_cmd(CCSC_OP_ERASE, 4'h0, 8'h00, KEY, 1'b0);
      do_cmd(CCSC_OP_PROGRAM, a, d, KEY, 1'b0);
      chk1(otp_set, 1'b1, "otp");
      end_sim();
   end
endmodule // test_config_security_seu_control

bind ccsc_top ccsc_top_chk #(.STORED_KEY(STORED_KEY)) u_chk (.*);
